// File: hw/modem_line_regs.svh
// bit positions, widths and reset values for the modem line block
`ifndef MODEM_LINE_REGS_SVH
`define MODEM_LINE_REGS_SVH
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_OUTA_BIT 2
`define MCR_OUTB_BIT 3
`define MCR_LOOP_BIT 4
`define MCR_WIDTH 5
`define MCR_PIN_COUNT 4
`define MCR_RESET 5'h00
`define MSR_RING_TRAILING_EDGE_FLAG_BIT 2
`define MSR_RING_BIT 6
`define MSR_WIDTH 8
`define PIN_INACTIVE 1'b1
`define SER_MARK 1'b1
`define EDGE_PIPE_RESET 2'h3
`endif

// File: hw/modem_line_pkg.sv
// types shared by the modem line block
`default_nettype none
package modem_line_pkg;
   typedef logic [4:0] mcr_t;
   typedef logic [7:0] msr_t;
endpackage
`default_nettype wire

// File: hw/ring_edge_detect.sv
// ring indicator sampling and trailing-edge flag
`timescale 1ns/10ps
`default_nettype none
`include "modem_line_regs.svh"
module ring_edge_detect (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic master_reset,
   input wire logic ring_n,
   input wire logic status_rd,
   output logic ring_level,
   output logic ring_trailing_edge_flag
);
   logic ring_q_r;
   logic ring_q_nxt;
   logic flag_nxt;
   logic rise;
   logic level_nxt;

   // low-to-high on the pin sets the flag; a set in the read cycle wins
   always_comb begin
      ring_q_nxt = ring_n;
      level_nxt = ~ring_n;
      rise = ring_n & ~ring_q_r;
      flag_nxt = ring_trailing_edge_flag;
      if (status_rd) begin
         flag_nxt = 1'b0;
      end
      if (rise) begin
         flag_nxt = 1'b1;
      end
      if (master_reset) begin
         flag_nxt = 1'b0;
         ring_q_nxt = `PIN_INACTIVE;
      end
   end

   // registers; ring_q_r resets high so no false edge after reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ring_q_r <= `PIN_INACTIVE;
         ring_level <= 1'b0;
         ring_trailing_edge_flag <= 1'b0;
      end else begin
         ring_q_r <= ring_q_nxt;
         ring_level <= level_nxt;
         ring_trailing_edge_flag <= flag_nxt;
      end
   end

   flag_on_rise_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (ring_n && !ring_q_r && !master_reset) |=> ring_trailing_edge_flag)
      else $error("ring rise did not set flag");
   flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (status_rd && !(ring_n && !ring_q_r)) |=> !ring_trailing_edge_flag)
      else $error("status read did not clear flag");
endmodule // ring_edge_detect
`default_nettype wire

// File: hw/modem_line_control.sv
// modem control and status pins of the serial communications element
// Contract
// - user output bit set in control register drives its pin low
// - user pins high on master reset, loop mode, or bit cleared
// - status bit 6 shows the current ring indicator condition
// - status bit 2 sets when ring input rises since last read
// - ring rise raises interrupt when modem status interrupt enabled
// - request-to-send bit set drives the request-to-send pin active
// - request-to-send high on master reset, loop mode, or bit cleared
// - serial output held marking while master reset applied
// - terminal-ready pin follows bit 0, high on reset or loop
`timescale 1ns/10ps
`default_nettype none
`include "modem_line_regs.svh"
module modem_line_control
   import modem_line_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic master_reset,
   input wire logic mcr_wr,
   input wire logic [`MCR_WIDTH-1:0] mcr_wdata,
   input wire logic msr_rd,
   input wire logic modem_int_en,
   input wire logic ring_n,
   input wire logic tx_serial,
   input wire logic rx_clk16,
   input wire logic serial_in,
   output logic [`MCR_WIDTH-1:0] modem_control_reg,
   output logic [`MSR_WIDTH-1:0] msr_rdata,
   output logic user_output_a_n,
   output logic user_output_b_n,
   output logic rts_n,
   output logic dtr_n,
   output logic serial_out,
   output logic modem_int,
   output logic loop_mode,
   output logic rx_clk16_q,
   output logic serial_in_q
);
   ////////////////////////////////////////////////////////////////////
   // next values and the registered pin vector
   mcr_t mcr_nxt;
   logic ring_level;
   logic ring_flag;
   logic int_nxt;
   msr_t msr_nxt;
   logic loop_nxt;
   logic serial_nxt;
   logic [`MCR_PIN_COUNT-1:0] pin_nxt;
   logic [`MCR_PIN_COUNT-1:0] pin_r;

   // ring sampling has its own module so the edge flag can be
   // reasoned about apart from the control pins
   ring_edge_detect u_ring (
      .mclk(mclk),
      .rst_b(rst_b),
      .master_reset(master_reset),
      .ring_n(ring_n),
      .status_rd(msr_rd),
      .ring_level(ring_level),
      .ring_trailing_edge_flag(ring_flag)
   );

   ////////////////////////////////////////////////////////////////////
   // control register; master reset clears it like the hard reset
   always_comb begin
      mcr_nxt = modem_control_reg;
      if (mcr_wr) begin
         mcr_nxt = mcr_wdata;
      end
      if (master_reset) begin
         mcr_nxt = `MCR_RESET;
      end
      loop_nxt = mcr_nxt[`MCR_LOOP_BIT];
   end

   // status read data and interrupt; interrupt follows the ring flag one cycle later, so it drops two cycles after a status read
   always_comb begin
      msr_nxt = '0;
      msr_nxt[`MSR_RING_BIT] = ring_level;
      msr_nxt[`MSR_RING_TRAILING_EDGE_FLAG_BIT] = ring_flag;
      int_nxt = modem_int_en & ring_flag;
      if (master_reset) begin
         int_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // composite serial output; loop mode parks it at mark so a self-test
   // never sends stray characters to the modem on the far side
   always_comb begin
      serial_nxt = tx_serial;
      if (master_reset | loop_nxt) begin
         serial_nxt = `SER_MARK;
      end
   end

   // one active-low pin per low control bit; the pins sit at control bits
   // 0 to 3, so the bit index doubles as the pin index
   for (genvar k = 0; k < `MCR_PIN_COUNT; k++) begin : g_pin
      assign pin_nxt[k] = ~(mcr_nxt[k] & ~loop_nxt);
   end

   // registers only; every next value but the two input samples is worked out above, and the hard
   // reset parks the pins inactive before any control write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         modem_control_reg <= `MCR_RESET;
         msr_rdata <= '0;
         pin_r <= {`MCR_PIN_COUNT{`PIN_INACTIVE}};
         serial_out <= `SER_MARK;
         modem_int <= 1'b0;
         loop_mode <= 1'b0;
         rx_clk16_q <= 1'b0;
         serial_in_q <= `SER_MARK;
      end else begin
         modem_control_reg <= mcr_nxt;
         msr_rdata <= msr_nxt;
         pin_r <= pin_nxt;
         serial_out <= serial_nxt;
         modem_int <= int_nxt;
         loop_mode <= loop_nxt;
         rx_clk16_q <= rx_clk16;
         serial_in_q <= serial_in;
      end
   end

   // pins come straight from the flop vector
   assign user_output_a_n = pin_r[`MCR_OUTA_BIT];
   assign user_output_b_n = pin_r[`MCR_OUTB_BIT];
   assign rts_n = pin_r[`MCR_RTS_BIT];
   assign dtr_n = pin_r[`MCR_DTR_BIT];

   ////////////////////////////////////////////////////////////////////
   sequence mr_seen;
      master_reset;
   endsequence
   sequence pins_idle;
      user_output_a_n && user_output_b_n && rts_n && dtr_n && serial_out;
   endsequence
   sequence write_taken;
      mcr_wr && !master_reset;
   endsequence
   sequence flag_up;
      $rose(ring_flag);
   endsequence
   sequence flag_down;
      $fell(ring_flag);
   endsequence

   reset_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
      mr_seen |=> pins_idle)
      else $error("pins not idle after master reset");
   out_a_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (mcr_wr && mcr_wdata[`MCR_OUTA_BIT] && !mcr_wdata[`MCR_LOOP_BIT]
      && !master_reset) |=> !user_output_a_n)
      else $error("user output a not active");
   out_b_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (mcr_wr && mcr_wdata[`MCR_OUTB_BIT] && !mcr_wdata[`MCR_LOOP_BIT]
      && !master_reset) |=> !user_output_b_n)
      else $error("user output b not active");
   loop_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
      loop_mode |-> (user_output_a_n && user_output_b_n && rts_n && dtr_n))
      else $error("pin active in loop mode");
   rts_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !loop_mode |-> (rts_n == !modem_control_reg[`MCR_RTS_BIT]))
      else $error("rts does not follow control bit");
   dtr_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !loop_mode |-> (dtr_n == !modem_control_reg[`MCR_DTR_BIT]))
      else $error("dtr does not follow control bit");
   mark_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
      mr_seen |=> serial_out)
      else $error("serial out not marking after reset");
   ring_int_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ($rose(ring_flag) && modem_int_en && !master_reset) |=> modem_int)
      else $error("ring rise gave no interrupt");
   ring_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ##1 (msr_rdata[`MSR_RING_BIT] == $past(ring_level)))
      else $error("status ring bit wrong");

   // control writes reach the register and the remaining pins
   mcr_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
      write_taken |=> (modem_control_reg == $past(mcr_wdata)))
      else $error("control register did not load");
   rts_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (mcr_wr && mcr_wdata[`MCR_RTS_BIT] && !mcr_wdata[`MCR_LOOP_BIT]
      && !master_reset) |=> !rts_n)
      else $error("request to send not active");
   dtr_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (mcr_wr && mcr_wdata[`MCR_DTR_BIT] && !mcr_wdata[`MCR_LOOP_BIT]
      && !master_reset) |=> !dtr_n)
      else $error("terminal ready not active");

   // master reset clears state that the pins do not show
   mr_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
      mr_seen |=> (modem_control_reg == `MCR_RESET && !modem_int))
      else $error("master reset left state behind");

   // transmit data passes through outside master reset and loop mode
   tx_pass_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (!master_reset && !loop_nxt) |=> (serial_out == $past(tx_serial)))
      else $error("serial out does not follow transmit data");

   // status register: spare bits, flag report and interrupt gating
   msr_spare_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (msr_rdata & ~((8'h01 << `MSR_RING_BIT) | (8'h01 << `MSR_RING_TRAILING_EDGE_FLAG_BIT)))
      == 8'h00)
      else $error("spare status bits not zero");
   flag_seen_a: assert property (@(posedge mclk) disable iff (!rst_b)
      flag_up |=> msr_rdata[`MSR_RING_TRAILING_EDGE_FLAG_BIT])
      else $error("ring flag not reported");
   int_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !modem_int_en |=> !modem_int)
      else $error("interrupt raised while disabled");
   int_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
      flag_down |=> !modem_int)
      else $error("interrupt held after flag cleared");
endmodule // modem_line_control
`default_nettype wire

// File: verif/modem_partner.sv
// behavioural modem on the far side of the modem control lines
`timescale 1ns/10ps
`default_nettype none
module modem_partner #(
   parameter int DIV = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ring_cmd,
   input wire logic serial_cmd,
   output logic ring_n,
   output logic serial_in,
   output var logic rx_clk16
);
   int cnt_r;
   // ring pin follows the bench command, active low at the connector
   assign ring_n = ring_cmd;
   // line data follows the bench; it rests at mark between tests
   assign serial_in = serial_cmd;
   ////////////////////////////////////////////////////////////////////////
   // receiver clock at sixteen times the baud rate; free running because
   // the receiver samples it even between characters
   always_ff @(negedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 0;
         rx_clk16 <= 1'b0;
      end else if (cnt_r == DIV - 1) begin
         cnt_r <= 0;
         rx_clk16 <= ~rx_clk16;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule // modem_partner
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the modem line control block
`timescale 1ns/10ps
`default_nettype none
`include "modem_line_regs.svh"
module tb;
   import modem_line_pkg::*;
   logic mclk, rst_b, master_reset, mcr_wr, msr_rd, modem_int_en;
   logic tx_serial, ring_cmd, ring_n, rx_clk16, serial_in;
   mcr_t mcr_wdata, modem_control_reg;
   msr_t msr_rdata;
   logic user_output_a_n, user_output_b_n, rts_n, dtr_n, serial_out;
   logic modem_int, loop_mode, rx_clk16_q, serial_in_q;
   logic serial_cmd, rclk_seen;
   int err_total, compares;
   modem_line_control modem_line_control_inst (.mclk(mclk), .rst_b(rst_b),
      .master_reset(master_reset), .mcr_wr(mcr_wr), .mcr_wdata(mcr_wdata),
      .msr_rd(msr_rd), .modem_int_en(modem_int_en), .ring_n(ring_n),
      .tx_serial(tx_serial), .rx_clk16(rx_clk16), .serial_in(serial_in),
      .modem_control_reg(modem_control_reg), .msr_rdata(msr_rdata),
      .user_output_a_n(user_output_a_n), .user_output_b_n(user_output_b_n),
      .rts_n(rts_n), .dtr_n(dtr_n), .serial_out(serial_out),
      .modem_int(modem_int), .loop_mode(loop_mode),
      .rx_clk16_q(rx_clk16_q), .serial_in_q(serial_in_q));
   modem_partner modem_partner_inst (.mclk(mclk), .rst_b(rst_b),
      .ring_cmd(ring_cmd), .serial_cmd(serial_cmd), .ring_n(ring_n),
      .serial_in(serial_in), .rx_clk16(rx_clk16));
   // receiver clock as the design saw it at each rising edge
   always @(posedge mclk) begin
      rclk_seen <= rx_clk16;
   end
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////
   // shared helpers; inputs only change at the falling edge
   task automatic chk(input string what, input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input mcr_t v);
      mcr_wr = 1'b1;
      mcr_wdata = v;
      cyc(1);
      mcr_wr = 1'b0;
   endtask
   // loop mode masks every pin back to its idle high level
   task automatic pins(input mcr_t m);
      logic [3:0] act;
      act = m[3:0] & {4{~m[4]}};
      chk("pins", {4'h0, user_output_b_n, user_output_a_n, rts_n, dtr_n},
         {4'h0, ~act});
   endtask
   task automatic tally_and_finish;
      if (err_total == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_b = 1'b0;
      master_reset = 1'b0;
      mcr_wr = 1'b0;
      mcr_wdata = 5'h00;
      msr_rd = 1'b0;
      modem_int_en = 1'b0;
      tx_serial = 1'b0;
      ring_cmd = 1'b1;
      serial_cmd = 1'b1;
      err_total = 0;
      compares = 0;
      cyc(12);
      chk("serial_out_rst", {7'h00, serial_out}, 8'h01);
      pins(5'h00);
      chk("sin_rst", {7'h00, serial_in_q}, 8'h01);
      rst_b = 1'b1;
      cyc(1);
      // every control pattern, loop bit included
      for (int i = 0; i < 32; i++) begin
         tx_serial = i[1];
         wr(i[4:0]);
         chk("mcr", {3'h0, modem_control_reg}, {3'h0, i[4:0]});
         pins(i[4:0]);
         chk("loop", {7'h00, loop_mode}, {7'h00, i[4]});
         cyc(1);
         chk("serial_out", {7'h00, serial_out}, {7'h00, i[4] | i[1]});
      end
      // master reset wins over a coincident write
      wr(5'h0f);
      tx_serial = 1'b0;
      cyc(1);
      pins(5'h0f);
      chk("serial_out_tx", {7'h00, serial_out}, 8'h00);
      master_reset = 1'b1;
      wr(5'h0f);
      master_reset = 1'b0;
      chk("serial_out_mr", {7'h00, serial_out}, 8'h01);
      chk("mcr_mr", {3'h0, modem_control_reg}, 8'h00);
      pins(5'h00);
      // ring rise with the interrupt off and then on
      for (int e = 0; e < 2; e++) begin
         modem_int_en = e[0];
         ring_cmd = 1'b0;
         cyc(4);
         chk("msr_low", msr_rdata, 8'h40);
         ring_cmd = 1'b1;
         cyc(4);
         chk("msr_rise", msr_rdata, 8'h04);
         chk("int_rise", {7'h00, modem_int}, {7'h00, e[0]});
         msr_rd = 1'b1;
         cyc(1);
         msr_rd = 1'b0;
         cyc(4);
         chk("msr_read", msr_rdata, 8'h00);
         chk("int_read", {7'h00, modem_int}, 8'h00);
      end
      // received data and receiver clock are passed on one edge later
      serial_cmd = 1'b0;
      cyc(1);
      chk("sin_low", {7'h00, serial_in_q}, 8'h00);
      serial_cmd = 1'b1;
      cyc(1);
      chk("sin_high", {7'h00, serial_in_q}, 8'h01);
      for (int c = 0; c < 16; c++) begin
         cyc(1);
         chk("rclk", {7'h00, rx_clk16_q}, {7'h00, rclk_seen});
      end
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
